/* shared/vird_pkg.sv */
// package: register map, field layout, reset values and format codes of the video input router
`default_nettype none
package vird_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] VIRD_OFS_FORMAT  = 8'h00;
  localparam logic [7:0] VIRD_OFS_SENSE_A = 8'h5D;
  localparam logic [7:0] VIRD_OFS_SENSE_B = 8'h5E;
  localparam logic [7:0] VIRD_OFS_DIAG_EN = 8'h5F;
  localparam logic [7:0] VIRD_OFS_STATUS  = 8'h60;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int VIRD_FMT_W      = 5;
  localparam int VIRD_PWRDN_BIT  = 6;
  localparam int VIRD_THR_LSB    = 2;
  localparam int VIRD_THR_W      = 3;
  localparam int VIRD_EN_BIT     = 0;
  localparam int VIRD_CH_W       = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [4:0] VIRD_FMT_RST   = 5'h00;
  localparam logic       VIRD_PWRDN_RST = 1'b1;
  localparam logic [2:0] VIRD_THR_RST   = 3'h3;
  localparam logic       VIRD_EN_RST    = 1'b0;

  // ****************************************
  // selection code boundaries
  // ****************************************
  localparam logic [4:0] VIRD_CODE_CVBS_LAST = 5'h07;
  localparam logic [4:0] VIRD_CODE_YC_FIRST  = 5'h08;
  localparam logic [4:0] VIRD_CODE_YC_LAST   = 5'h0B;
  localparam logic [4:0] VIRD_CODE_CMP_FIRST = 5'h0C;
  localparam logic [4:0] VIRD_CODE_CMP_LAST  = 5'h0D;
  localparam logic [4:0] VIRD_CODE_DIF_FIRST = 5'h0E;
  localparam logic [4:0] VIRD_CODE_DIF_LAST  = 5'h11;

  // format handed to the standard definition processor
  typedef enum logic [2:0] {
    VIRD_FMT_NONE,
    VIRD_FMT_CVBS,
    VIRD_FMT_DIFF,
    VIRD_FMT_YC,
    VIRD_FMT_COMP
  } vird_format_e;
endpackage
`default_nettype wire

/* shared/vird_route_if.sv */
// interface: decoded routing passed from the code decoder to the top
`timescale 1ns/1ns
`default_nettype none
interface vird_route_if;
  import vird_pkg::*;
  vird_format_e format;
  logic [2:0]   primary_ch;
  logic [2:0]   second_ch;
  logic [2:0]   third_ch;
  logic [7:0]   powerup_mask;

  modport dec (output format, output primary_ch, output second_ch, output third_ch, output powerup_mask);
  modport top (input format, input primary_ch, input second_ch, input third_ch, input powerup_mask);
endinterface
`default_nettype wire

/* logic/vird_route_decode.sv */
// module: turns the 5-bit selection code into a fixed analog routing
`timescale 1ns/1ns
`default_nettype none
module vird_route_decode
  import vird_pkg::*;
(
  // selection code
  input  wire logic [4:0] code,
  // decoded routing
  vird_route_if.dec       route
);
  logic [2:0] idx;

  // ****************************************
  // code decode
  // ****************************************
  // exactly one routing per code, reserved codes route nothing
  always_comb begin
    idx                = 3'h0;
    route.format       = VIRD_FMT_NONE;
    route.primary_ch   = 3'h0;
    route.second_ch    = 3'h0;
    route.third_ch     = 3'h0;
    route.powerup_mask = 8'h00;
    if (code <= VIRD_CODE_CVBS_LAST) begin
      idx                = code[2:0];
      route.format       = VIRD_FMT_CVBS;
      route.primary_ch   = idx;
      route.powerup_mask = 8'h01 << idx;
    end else if (code <= VIRD_CODE_YC_LAST) begin
      idx                = {code[1:0] - VIRD_CODE_YC_FIRST[1:0], 1'b0};
      route.format       = VIRD_FMT_YC;
      route.primary_ch   = idx;
      route.second_ch    = idx + 3'h1;
      route.powerup_mask = 8'h03 << idx;
    end else if (code <= VIRD_CODE_CMP_LAST) begin
      idx                = (code == VIRD_CODE_CMP_FIRST) ? 3'h0 : 3'h3;
      route.format       = VIRD_FMT_COMP;
      route.primary_ch   = idx;
      route.second_ch    = idx + 3'h1;
      route.third_ch     = idx + 3'h2;
      route.powerup_mask = 8'h07 << idx;
    end else if (code <= VIRD_CODE_DIF_LAST) begin
      idx                = {code[1:0] - VIRD_CODE_DIF_FIRST[1:0], 1'b0};
      route.format       = VIRD_FMT_DIFF;
      route.primary_ch   = idx;
      route.second_ch    = idx + 3'h1;
      route.powerup_mask = 8'h03 << idx;
    end
  end
endmodule
`default_nettype wire

/* logic/vird_short_monitor.sv */
// module: sticky short-to-battery flags for the two fault sense pins
`timescale 1ns/1ns
`default_nettype none
module vird_short_monitor
  import vird_pkg::*;
#(
  parameter int PINS = 2
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // control
  input  wire logic            diag_enable,
  input  wire logic [PINS-1:0] powerdown,
  input  wire logic [PINS-1:0] clear,
  // comparator results, high while the pin is above its threshold
  input  wire logic [PINS-1:0] above,
  // latched events
  output logic      [PINS-1:0] battery_short_event
);
  // ****************************************
  // per-pin event latch
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      // armed only when enabled and powered, set beats clear
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          battery_short_event[i] <= 1'b0;
        end else if (diag_enable && !powerdown[i] && above[i]) begin
          battery_short_event[i] <= 1'b1;
        end else if (clear[i]) begin
          battery_short_event[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* logic/vird_top.sv */
// module: video input routing and short-to-battery monitor, top level
// Operation
// - The input format selection is a 5-bit software-writable field at bits 4:0 of register 0x00.
// - The selection both routes the channels and tells the processing core which format to handle.
// - Channels the selection does not use are powered down with no other programming.
// - Codes 0 to 7 select single-ended composite on analog input n+1.
// - Codes 8 to 11 select luma/chroma on input pairs 1/2, 3/4, 5/6 and 7/8.
// - Code 12 selects component on inputs 1,2,3 and code 13 on inputs 4,5,6.
// - Codes 14 to 17 select differential composite on pairs 1/2 to 7/8, higher codes are reserved.
// - Each sense pin above its programmable threshold counts as a short-to-battery event.
// - An event on either sense pin raises the interrupt request pin.
// - A readable status register shows which sense pin saw the event.
// - The diagnostic function is off after reset and must be enabled by software.
// - Each sense pin has a power-down bit 6, reset to 1, written 0 to power up.
// - Each sense pin has a 3-bit threshold in bits 4:2 that resets to 011.
`timescale 1ns/1ns
`default_nettype none
module vird_top
  import vird_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  // routing to the analog front end and processing core
  output vird_format_e      standard_def_processor_format,
  output logic      [2:0]   route_primary_ch,
  output logic      [2:0]   route_second_ch,
  output logic      [2:0]   route_third_ch,
  output logic      [7:0]   analog_input_channel_powerup,
  // fault sense comparators
  input  wire logic         sense_a_above,
  input  wire logic         sense_b_above,
  output logic              sense_a_powerdown,
  output logic              sense_b_powerdown,
  output logic      [2:0]   sense_a_threshold,
  output logic      [2:0]   sense_b_threshold,
  // interrupt
  output logic              interrupt_request_pin
);
  logic [4:0] input_format_select;
  logic       diag_enable;
  logic [1:0] battery_short_event;
  logic [1:0] status_clear;
  logic       wr_format;
  logic       wr_sense_a;
  logic       wr_sense_b;
  logic       wr_diag_en;
  logic       wr_status;
  logic [7:0] next_rdata;

  vird_route_if route ();

  // ****************************************
  // write decode
  // ****************************************
  always_comb begin
    wr_format  = 1'b0;
    wr_sense_a = 1'b0;
    wr_sense_b = 1'b0;
    wr_diag_en = 1'b0;
    wr_status  = 1'b0;
    if (reg_wr && reg_addr == VIRD_OFS_FORMAT) begin
      wr_format = 1'b1;
    end else if (reg_wr && reg_addr == VIRD_OFS_SENSE_A) begin
      wr_sense_a = 1'b1;
    end else if (reg_wr && reg_addr == VIRD_OFS_SENSE_B) begin
      wr_sense_b = 1'b1;
    end else if (reg_wr && reg_addr == VIRD_OFS_DIAG_EN) begin
      wr_diag_en = 1'b1;
    end else if (reg_wr && reg_addr == VIRD_OFS_STATUS) begin
      wr_status = 1'b1;
    end
  end

  // write-one-to-clear of the event flags
  assign status_clear = wr_status ? reg_wdata[1:0] : 2'h0;

  // ****************************************
  // registers
  // ****************************************
  // format selection field
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_format_select <= VIRD_FMT_RST;
    end else if (wr_format) begin
      input_format_select <= reg_wdata[VIRD_FMT_W-1:0];
    end
  end

  // sense pin a control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_a_powerdown <= VIRD_PWRDN_RST;
      sense_a_threshold <= VIRD_THR_RST;
    end else if (wr_sense_a) begin
      sense_a_powerdown <= reg_wdata[VIRD_PWRDN_BIT];
      sense_a_threshold <= reg_wdata[VIRD_THR_LSB +: VIRD_THR_W];
    end
  end

  // sense pin b control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_b_powerdown <= VIRD_PWRDN_RST;
      sense_b_threshold <= VIRD_THR_RST;
    end else if (wr_sense_b) begin
      sense_b_powerdown <= reg_wdata[VIRD_PWRDN_BIT];
      sense_b_threshold <= reg_wdata[VIRD_THR_LSB +: VIRD_THR_W];
    end
  end

  // diagnostic enable, off after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      diag_enable <= VIRD_EN_RST;
    end else if (wr_diag_en) begin
      diag_enable <= reg_wdata[VIRD_EN_BIT];
    end
  end

  // ****************************************
  // read back
  // ****************************************
  // unmapped addresses and unused bits read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == VIRD_OFS_FORMAT) begin
      next_rdata[VIRD_FMT_W-1:0] = input_format_select;
    end else if (reg_addr == VIRD_OFS_SENSE_A) begin
      next_rdata[VIRD_PWRDN_BIT] = sense_a_powerdown;
      next_rdata[VIRD_THR_LSB +: VIRD_THR_W] = sense_a_threshold;
    end else if (reg_addr == VIRD_OFS_SENSE_B) begin
      next_rdata[VIRD_PWRDN_BIT] = sense_b_powerdown;
      next_rdata[VIRD_THR_LSB +: VIRD_THR_W] = sense_b_threshold;
    end else if (reg_addr == VIRD_OFS_DIAG_EN) begin
      next_rdata[VIRD_EN_BIT] = diag_enable;
    end else if (reg_addr == VIRD_OFS_STATUS) begin
      next_rdata[1:0] = battery_short_event;
    end
  end

  // read data captured on the read strobe and held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // routing
  // ****************************************
  vird_route_decode u_decode (
    .code  (input_format_select),
    .route (route)
  );

  // decoded routing registered onto the outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      standard_def_processor_format <= VIRD_FMT_NONE;
      route_primary_ch              <= 3'h0;
      route_second_ch               <= 3'h0;
      route_third_ch                <= 3'h0;
      analog_input_channel_powerup  <= 8'h00;
    end else begin
      standard_def_processor_format <= route.format;
      route_primary_ch              <= route.primary_ch;
      route_second_ch               <= route.second_ch;
      route_third_ch                <= route.third_ch;
      analog_input_channel_powerup  <= route.powerup_mask;
    end
  end

  // ****************************************
  // short-to-battery monitor
  // ****************************************
  vird_short_monitor #(
    .PINS (2)
  ) u_monitor (
    .clk                 (clk),
    .rst_n               (rst_n),
    .diag_enable         (diag_enable),
    .powerdown           ({sense_b_powerdown, sense_a_powerdown}),
    .clear               (status_clear),
    .above               ({sense_b_above, sense_a_above}),
    .battery_short_event (battery_short_event)
  );

  // interrupt follows any latched event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_request_pin <= 1'b0;
    end else begin
      interrupt_request_pin <= |battery_short_event;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_format_write;
    reg_wr && reg_addr == VIRD_OFS_FORMAT |=> input_format_select == $past(reg_wdata[4:0]);
  endproperty
  a_format_write: assert property (p_format_write) else $error("format field not written");

  property p_cvbs_route;
    input_format_select <= VIRD_CODE_CVBS_LAST |=>
      standard_def_processor_format == VIRD_FMT_CVBS &&
      analog_input_channel_powerup == (8'h01 << $past(input_format_select[2:0]));
  endproperty
  a_cvbs_route: assert property (p_cvbs_route) else $error("composite routing wrong");

  property p_yc_route;
    input_format_select >= VIRD_CODE_YC_FIRST && input_format_select <= VIRD_CODE_YC_LAST |=>
      standard_def_processor_format == VIRD_FMT_YC && route_second_ch == route_primary_ch + 3'h1 &&
      route_primary_ch == {$past(input_format_select[1:0]), 1'b0};
  endproperty
  a_yc_route: assert property (p_yc_route) else $error("luma chroma routing wrong");

  property p_comp_route;
    input_format_select == VIRD_CODE_CMP_LAST |=>
      standard_def_processor_format == VIRD_FMT_COMP && analog_input_channel_powerup == 8'h38;
  endproperty
  a_comp_route: assert property (p_comp_route) else $error("component routing wrong");

  property p_diff_route;
    input_format_select == VIRD_CODE_DIF_LAST |=>
      standard_def_processor_format == VIRD_FMT_DIFF && analog_input_channel_powerup == 8'hC0;
  endproperty
  a_diff_route: assert property (p_diff_route) else $error("differential routing wrong");

  property p_reserved;
    input_format_select > VIRD_CODE_DIF_LAST |=>
      analog_input_channel_powerup == 8'h00 && standard_def_processor_format == VIRD_FMT_NONE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code routes a channel");

  property p_unused_off;
    standard_def_processor_format == VIRD_FMT_CVBS |-> $onehot(analog_input_channel_powerup);
  endproperty
  a_unused_off: assert property (p_unused_off) else $error("unused channels powered");

  property p_disabled_quiet;
    !diag_enable && battery_short_event == 2'h0 |=> battery_short_event == 2'h0;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("event while disabled");

  property p_event_irq;
    diag_enable && !sense_a_powerdown && sense_a_above |=> battery_short_event[0] ##1 interrupt_request_pin;
  endproperty
  a_event_irq: assert property (p_event_irq) else $error("event did not raise interrupt");

  property p_sticky;
    battery_short_event[1] && !status_clear[1] |=> battery_short_event[1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("event dropped without clear");

  property p_status_read;
    reg_rd && reg_addr == VIRD_OFS_STATUS |=> reg_rdata == {6'h00, $past(battery_short_event)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_event_irq_b;
    diag_enable && !sense_b_powerdown && sense_b_above |=> battery_short_event[1] ##1 interrupt_request_pin;
  endproperty
  a_event_irq_b: assert property (p_event_irq_b) else $error("pin b event did not raise interrupt");

  property p_sticky_a;
    battery_short_event[0] && !status_clear[0] |=> battery_short_event[0];
  endproperty
  a_sticky_a: assert property (p_sticky_a) else $error("pin a event dropped without clear");

  property p_powered_down_quiet;
    sense_a_powerdown && !battery_short_event[0] |=> !battery_short_event[0];
  endproperty
  a_powered_down_quiet: assert property (p_powered_down_quiet) else $error("event on powered down pin");

  property p_irq_clear;
    battery_short_event == 2'h0 |=> !interrupt_request_pin;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt held with no event");

  property p_comp_first;
    input_format_select == VIRD_CODE_CMP_FIRST |=>
      analog_input_channel_powerup == 8'h07 && route_primary_ch == 3'h0 &&
      route_second_ch == 3'h1 && route_third_ch == 3'h2;
  endproperty
  a_comp_first: assert property (p_comp_first) else $error("low component routing wrong");

  property p_sense_a_write;
    reg_wr && reg_addr == VIRD_OFS_SENSE_A |=>
      sense_a_powerdown == $past(reg_wdata[6]) && sense_a_threshold == $past(reg_wdata[4:2]);
  endproperty
  a_sense_a_write: assert property (p_sense_a_write) else $error("sense pin a control not written");

  property p_diag_write;
    reg_wr && reg_addr == VIRD_OFS_DIAG_EN |=> diag_enable == $past(reg_wdata[0]);
  endproperty
  a_diag_write: assert property (p_diag_write) else $error("diagnostic enable not written");
endmodule
`default_nettype wire

/* dv/vird_sense_model.sv */
// partner model: fault sense comparators fed by adjustable harness voltages
`timescale 1ns/1ns
`default_nettype none
module vird_sense_model (
  // clock
  input  wire logic       clk,
  // harness voltages, in threshold steps
  input  wire logic [3:0] level_a,
  input  wire logic [3:0] level_b,
  // slicer controls from the device
  input  wire logic       powerdown_a,
  input  wire logic       powerdown_b,
  input  wire logic [2:0] threshold_a,
  input  wire logic [2:0] threshold_b,
  // synchronous comparator results
  output logic            above_a,
  output logic            above_b
);
  // ****************************************
  // slicers
  // ****************************************
  // a powered-down slicer reports nothing; a level equal to the threshold is not above it
  always_ff @(posedge clk) begin
    above_a <= !powerdown_a && (level_a > {1'b0, threshold_a});
    above_b <= !powerdown_b && (level_b > {1'b0, threshold_b});
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// testbench: routing table, register port and short-to-battery monitor of the video input router
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import vird_pkg::*;
  typedef struct {
    logic [4:0]   code;
    vird_format_e fmt;
    logic [2:0]   pri;
    logic [2:0]   sec;
    logic [2:0]   thi;
    logic [7:0]   mask;
  } vird_row_s;
  // ****************************************
  // signals
  // ****************************************
  logic         clk;
  logic         rst_n;
  logic [7:0]   reg_addr;
  logic [7:0]   reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [7:0]   reg_rdata;
  vird_format_e fmt;
  logic [2:0]   pri;
  logic [2:0]   sec;
  logic [2:0]   thi;
  logic [7:0]   pwr;
  logic         above_a;
  logic         above_b;
  logic         pd_a;
  logic         pd_b;
  logic [2:0]   thr_a;
  logic [2:0]   thr_b;
  logic         irq;
  logic [3:0]   level_a;
  logic [3:0]   level_b;
  int           n_mismatch;
  int           total_checks;
  vird_row_s    rows[20];

  // clock of 4 ns
  always #2 clk = ~clk;

  // device and harness comparators
  vird_top dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standard_def_processor_format(fmt), .route_primary_ch(pri),
    .route_second_ch(sec), .route_third_ch(thi), .analog_input_channel_powerup(pwr),
    .sense_a_above(above_a), .sense_b_above(above_b), .sense_a_powerdown(pd_a), .sense_b_powerdown(pd_b),
    .sense_a_threshold(thr_a), .sense_b_threshold(thr_b), .interrupt_request_pin(irq));
  vird_sense_model model_u (.clk(clk), .level_a(level_a), .level_b(level_b), .powerdown_a(pd_a),
    .powerdown_b(pd_b), .threshold_a(thr_a), .threshold_b(thr_b), .above_a(above_a), .above_b(above_b));

  // ****************************************
  // helpers
  // ****************************************
  // expected routing of one selection code
  function automatic vird_row_s make_row(input int c);
    vird_row_s r;
    int        k;
    r = '{code: c[4:0], fmt: VIRD_FMT_NONE, pri: 3'h0, sec: 3'h0, thi: 3'h0, mask: 8'h00};
    k = (c >= 14) ? c - 14 : c - 8;
    if (c <= 7) begin
      r.fmt = VIRD_FMT_CVBS;
      r.pri = c[2:0];
      r.mask = 8'h01 << c;
    end else if (c <= 11 || (c >= 14 && c <= 17)) begin
      r.fmt = (c <= 11) ? VIRD_FMT_YC : VIRD_FMT_DIFF;
      r.pri = 3'(2 * k);
      r.sec = 3'(2 * k + 1);
      r.mask = 8'h03 << (2 * k);
    end else if (c <= 13) begin
      r.fmt = VIRD_FMT_COMP;
      r.pri = (c == 12) ? 3'h0 : 3'h3;
      r.sec = (c == 12) ? 3'h1 : 3'h4;
      r.thi = (c == 12) ? 3'h2 : 3'h5;
      r.mask = (c == 12) ? 8'h07 : 8'h38;
    end
    return r;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_route(input vird_row_s r);
    logic [19:0] got;
    logic [19:0] exp;
    got = {fmt, pri, sec, thi, pwr};
    exp = {r.fmt, r.pri, r.sec, r.thi, r.mask};
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: route got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    chk_val(reg_rdata, exp);
  endtask

  // bounded wait for the interrupt line to reach a level
  task automatic wait_irq(input logic exp);
    int i;
    for (i = 0; i < 8 && irq !== exp; i++) cyc(1);
    if (irq !== exp) begin
      n_mismatch++;
      $display("Error at %0t: interrupt got %h expected %h", $time, irq, exp);
      complete_run();
    end else begin
      chk_val({7'h0, irq}, {7'h0, exp});
    end
  endtask

  task automatic chk_reset_outputs();
    chk_route(make_row(18));
    chk_val({pd_b, pd_a, thr_b, thr_a}, {1'b1, 1'b1, 3'h3, 3'h3});
    chk_val({7'h0, irq}, 8'h00);
    chk_val(reg_rdata, 8'h00);
  endtask

  task automatic end_test(input string name);
    $display("test %s done, checks %0d mismatches %0d", name, total_checks, n_mismatch);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
    {level_a, level_b} = 8'h00;
    n_mismatch = 0;
    total_checks = 0;
    for (int i = 0; i < 20; i++) rows[i] = make_row((i < 19) ? i : 31);
    cyc(8);
    chk_reset_outputs();
    rst_n = 1'b1;
    cyc(2);
    chk_route(rows[0]);
    rd_chk(VIRD_OFS_SENSE_A, 8'h4C);
    rd_chk(VIRD_OFS_SENSE_B, 8'h4C);
    rd_chk(VIRD_OFS_DIAG_EN, 8'h00);
    rd_chk(VIRD_OFS_STATUS, 8'h00);
    end_test("reset");
    // selection codes 0 to 18 and 31, reserved ones included
    foreach (rows[i]) begin
      wr(VIRD_OFS_FORMAT, {3'h0, rows[i].code});
      chk_route(rows[i]);
      rd_chk(VIRD_OFS_FORMAT, {3'h0, rows[i].code});
    end
    end_test("routing table");
    // upper bits dropped, unmapped space ignored
    wr(VIRD_OFS_FORMAT, 8'hE3);
    wr(8'h33, 8'hFF);
    rd_chk(VIRD_OFS_FORMAT, 8'h03);
    rd_chk(8'h33, 8'h00);
    chk_route(rows[3]);
    end_test("register edges");
    // powered sensor but diagnostics still disabled
    wr(VIRD_OFS_SENSE_A, 8'h0C);
    level_a = 4'h8;
    cyc(6);
    rd_chk(VIRD_OFS_STATUS, 8'h00);
    chk_val({7'h0, irq}, 8'h00);
    level_a = 4'h0;
    wr(VIRD_OFS_SENSE_A, 8'h14);
    chk_val({4'h0, pd_a, thr_a}, 8'h05);
    wr(VIRD_OFS_DIAG_EN, 8'h01);
    level_a = 4'h5;
    cyc(6);
    rd_chk(VIRD_OFS_STATUS, 8'h00);
    level_a = 4'h6;
    wait_irq(1'b1);
    level_a = 4'h0;
    cyc(4);
    rd_chk(VIRD_OFS_STATUS, 8'h01);
    chk_val({7'h0, irq}, 8'h01);
    wr(VIRD_OFS_STATUS, 8'h01);
    wait_irq(1'b0);
    rd_chk(VIRD_OFS_STATUS, 8'h00);
    end_test("sense a");
    // pin b ignored while powered down, then trips
    level_b = 4'h8;
    cyc(6);
    rd_chk(VIRD_OFS_STATUS, 8'h00);
    wr(VIRD_OFS_SENSE_B, 8'h0C);
    wait_irq(1'b1);
    wr(VIRD_OFS_STATUS, 8'h02);
    rd_chk(VIRD_OFS_STATUS, 8'h02);
    level_b = 4'h0;
    rd_chk(VIRD_OFS_STATUS, 8'h02);
    wr(VIRD_OFS_STATUS, 8'h02);
    wait_irq(1'b0);
    end_test("sense b");
    // reset in mid-run restores defaults
    wr(VIRD_OFS_FORMAT, 8'h0D);
    rst_n = 1'b0;
    cyc(2);
    chk_reset_outputs();
    rst_n = 1'b1;
    cyc(2);
    chk_route(rows[0]);
    rd_chk(VIRD_OFS_FORMAT, 8'h00);
    rd_chk(VIRD_OFS_DIAG_EN, 8'h00);
    rd_chk(VIRD_OFS_SENSE_A, 8'h4C);
    end_test("second reset");
    complete_run();
  end
endmodule
`default_nettype wire
